// ### hdl/lsr_exec.sv
// Execution sequencer for the OR, stack, return, rotate and bit set group.
//
// How it works
// - OR into a port reads its output latch, flagged by the MEM_RMW strobe.
// - Opcode 0x48-0x4F ORs working register into accumulator.
// - 0x45 ORs direct byte, 0x46/0x47 OR indirect byte into accumulator.
// - 0x44 ORs immediate into accumulator; 0x42 ORs accumulator into direct.
// - 0x43 ORs third-byte mask into the direct byte of second byte.
// - 0x72 sets carry when addressed bit is one, else carry unchanged.
// - 0xA0 ORs inverted addressed bit into carry; bit itself untouched.
// - Pop reads RAM at stack pointer, decrements, writes direct byte.
// - Pop into the stack pointer decrements first, then loads popped value.
// - Push increments stack pointer then stores direct byte at it.
// - Return pops high then low program counter byte, decrementing each.
// - Interrupt return restores counter likewise and releases its level.
// - Interrupt return alters only counter, stack pointer, priority state.
// - After interrupt return one more instruction runs before vectoring.
// - Rotate left moves bit 7 into bit 0; carry untouched.
// - Rotate left through carry: bit 7 to carry, old carry to bit 0.
// - Rotate right moves bit 0 into bit 7; carry untouched.
// - Rotate right through carry: bit 0 to carry, old carry to bit 7.
// - Bit set forces carry (0xD3) or an addressed bit (0xD2) to one.
// - Byte OR forms store bitwise OR in destination, flags untouched.
`timescale 1ns/1ps
module lsr_exec (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic EXEC_START,
  input wire logic [7:0] EXEC_OPCODE,
  input wire logic [7:0] EXEC_OPND1,
  input wire logic [7:0] EXEC_OPND2,
  input wire logic [1:0] REG_BANK,
  input wire logic [7:0] MEM_RDATA,
  output logic [7:0] MEM_ADDR,
  output logic MEM_DIRECT,
  output logic MEM_RD,
  output logic MEM_RMW,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  output logic EXEC_BUSY,
  output logic EXEC_DONE,
  output logic EXEC_ILLEGAL,
  output logic [7:0] ACC_Q,
  output logic CY_Q,
  output logic [7:0] SP_Q,
  output logic [15:0] PC_Q,
  output logic PRIO_RELEASE,
  output logic IRQ_DEFER
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  lsr_pkg::lsr_state_t state_ff, nxt_state;
  lsr_pkg::lsr_cls_t cls_ff, nxt_cls, dec_cls, alu_cls;
  logic [7:0] op1_ff, nxt_op1, op2_ff, nxt_op2;
  logic [7:0] acc_ff, nxt_acc, sp_ff, nxt_sp, pch_ff, nxt_pch;
  logic cy_ff, nxt_cy;
  logic [15:0] pc_ff, nxt_pc, dec_len;
  logic [7:0] addr_ff, nxt_addr, wdata_ff, nxt_wdata;
  logic direct_ff, nxt_direct, rd_ff, nxt_rd, rmw_ff, nxt_rmw;
  logic wr_ff, nxt_wr, busy_ff, nxt_busy, done_ff, nxt_done;
  logic bad_ff, nxt_bad, prel_ff, nxt_prel, defer_ff, nxt_defer;

  logic [7:0] op1_sel, op2_sel, reg_addr, bit_byte, rd_val, alu_res;
  logic [7:0] w_addr;
  logic [2:0] bit_idx, reg_sel;
  logic alu_cy;

  // --------------------------------------------------------------------------
  // Decode of the incoming opcode into a class and a length.
  // --------------------------------------------------------------------------
  always_comb begin
    dec_cls = lsr_pkg::CL_BAD;
    dec_len = lsr_pkg::LEN_1;
    if ((EXEC_OPCODE & 8'hF8) == lsr_pkg::OPC_OR_RN_BASE) begin
      dec_cls = lsr_pkg::CL_OR_RN;
    end else if ((EXEC_OPCODE & 8'hFE) == lsr_pkg::OPC_OR_IND_BASE) begin
      dec_cls = lsr_pkg::CL_OR_IND;
    end else begin
      case (EXEC_OPCODE)
        lsr_pkg::OPC_OR_DIR: begin
          dec_cls = lsr_pkg::CL_OR_DIR;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_OR_IMM: begin
          dec_cls = lsr_pkg::CL_OR_IMM;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_OR_DIR_A: begin
          dec_cls = lsr_pkg::CL_OR_DIR_A;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_OR_DIR_IMM: begin
          dec_cls = lsr_pkg::CL_OR_DIR_IMM;
          dec_len = lsr_pkg::LEN_3;
        end
        lsr_pkg::OPC_OR_C_BIT: begin
          dec_cls = lsr_pkg::CL_OR_C_BIT;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_OR_C_NBIT: begin
          dec_cls = lsr_pkg::CL_OR_C_NBIT;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_POP: begin
          dec_cls = lsr_pkg::CL_POP;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_PUSH: begin
          dec_cls = lsr_pkg::CL_PUSH;
          dec_len = lsr_pkg::LEN_2;
        end
        lsr_pkg::OPC_RET: dec_cls = lsr_pkg::CL_RET;
        lsr_pkg::OPC_INTERRUPT_EXIT_OP: dec_cls = lsr_pkg::CL_INTERRUPT_EXIT_OP;
        lsr_pkg::OPC_RL: dec_cls = lsr_pkg::CL_RL;
        lsr_pkg::OPC_RLC: dec_cls = lsr_pkg::CL_RLC;
        lsr_pkg::OPC_RR: dec_cls = lsr_pkg::CL_RR;
        lsr_pkg::OPC_RRC: dec_cls = lsr_pkg::CL_RRC;
        lsr_pkg::OPC_SET_BIT_OP_C: dec_cls = lsr_pkg::CL_SET_BIT_OP_C;
        lsr_pkg::OPC_SET_BIT_OP_BIT: begin
          dec_cls = lsr_pkg::CL_SET_BIT_OP_BIT;
          dec_len = lsr_pkg::LEN_2;
        end
        default: dec_cls = lsr_pkg::CL_BAD;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Operand steering and helpers
  // --------------------------------------------------------------------------
  // In idle the ALU sees the incoming instruction so one-cycle forms finish
  // without a second pass through the sequencer.
  assign alu_cls = (state_ff == lsr_pkg::ST_IDLE) ? dec_cls : cls_ff;
  assign op1_sel = (state_ff == lsr_pkg::ST_IDLE) ? EXEC_OPND1 : op1_ff;
  assign op2_sel = (state_ff == lsr_pkg::ST_IDLE) ? EXEC_OPND2 : op2_ff;
  // Indirect forms only ever point through the first two registers.
  assign reg_sel = (state_ff != lsr_pkg::ST_IDLE) ? 3'h0 :
                   (dec_cls == lsr_pkg::CL_OR_IND) ? {2'h0, EXEC_OPCODE[0]} :
                   EXEC_OPCODE[2:0];
  // Stack pointer and accumulator are held here, so their direct addresses
  // are served locally rather than from the outside bus.
  assign rd_val = (direct_ff && addr_ff == lsr_pkg::SP_ADDR) ? sp_ff :
                  (direct_ff && addr_ff == lsr_pkg::ACC_ADDR) ? acc_ff :
                  MEM_RDATA;
  assign w_addr = (cls_ff == lsr_pkg::CL_SET_BIT_OP_BIT) ? bit_byte : op1_ff;

  lsr_addr u_addr (
    .bank(REG_BANK),
    .reg_sel(reg_sel),
    .bit_addr(op1_sel),
    .reg_addr(reg_addr),
    .bit_byte(bit_byte),
    .bit_idx(bit_idx)
  );

  lsr_alu u_alu (
    .cls(alu_cls),
    .acc(acc_ff),
    .cy(cy_ff),
    .opnd(rd_val),
    .op1(op1_sel),
    .op2(op2_sel),
    .bit_idx(bit_idx),
    .res(alu_res),
    .res_cy(alu_cy)
  );

  // --------------------------------------------------------------------------
  // Sequencer next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cls = cls_ff;
    nxt_op1 = op1_ff;
    nxt_op2 = op2_ff;
    nxt_acc = acc_ff;
    nxt_cy = cy_ff;
    nxt_sp = sp_ff;
    nxt_pch = pch_ff;
    nxt_pc = pc_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_direct = direct_ff;
    nxt_rd = 1'b0;
    nxt_rmw = 1'b0;
    nxt_wr = 1'b0;
    nxt_done = 1'b0;
    nxt_bad = 1'b0;
    nxt_prel = 1'b0;
    nxt_defer = defer_ff;
    nxt_busy = busy_ff;
    case (state_ff)
      lsr_pkg::ST_IDLE: begin
        if (EXEC_START) begin
          nxt_cls = dec_cls;
          nxt_op1 = EXEC_OPND1;
          nxt_op2 = EXEC_OPND2;
          nxt_pc = pc_ff + dec_len;
          nxt_busy = 1'b1;
          nxt_rd = 1'b1;
          nxt_direct = 1'b1;
          nxt_addr = EXEC_OPND1;
          nxt_state = lsr_pkg::ST_OPND;
          case (dec_cls)
            lsr_pkg::CL_OR_RN: nxt_direct = 1'b0;
            lsr_pkg::CL_OR_DIR: nxt_direct = 1'b1;
            lsr_pkg::CL_OR_IND: begin
              nxt_direct = 1'b0;
              nxt_addr = reg_addr;
              nxt_state = lsr_pkg::ST_PTR;
            end
            lsr_pkg::CL_OR_DIR_A,
            lsr_pkg::CL_OR_DIR_IMM: nxt_rmw = 1'b1;
            lsr_pkg::CL_SET_BIT_OP_BIT: begin
              nxt_rmw = 1'b1;
              nxt_addr = bit_byte;
            end
            lsr_pkg::CL_OR_C_BIT,
            lsr_pkg::CL_OR_C_NBIT: nxt_addr = bit_byte;
            lsr_pkg::CL_POP, lsr_pkg::CL_RET, lsr_pkg::CL_INTERRUPT_EXIT_OP: begin
              nxt_direct = 1'b0;
              nxt_addr = sp_ff;
            end
            lsr_pkg::CL_PUSH: nxt_sp = sp_ff + 8'h01;
            default: begin
              // One-cycle forms and illegal opcodes finish here.
              nxt_rd = 1'b0;
              nxt_busy = 1'b0;
              nxt_state = lsr_pkg::ST_IDLE;
              nxt_acc = alu_res;
              nxt_cy = alu_cy;
              nxt_done = 1'b1;
              nxt_bad = (dec_cls == lsr_pkg::CL_BAD);
              nxt_defer = 1'b0;
            end
          endcase
          if (dec_cls == lsr_pkg::CL_OR_RN) begin
            nxt_addr = reg_addr;
          end
        end
      end
      lsr_pkg::ST_PTR: begin
        // The pointer register value becomes the indirect address.
        nxt_rd = 1'b1;
        nxt_addr = rd_val;
        nxt_state = lsr_pkg::ST_OPND;
      end
      lsr_pkg::ST_OPND: begin
        nxt_state = lsr_pkg::ST_IDLE;
        nxt_done = 1'b1;
        case (cls_ff)
          lsr_pkg::CL_OR_C_BIT,
          lsr_pkg::CL_OR_C_NBIT: nxt_cy = alu_cy;
          lsr_pkg::CL_PUSH: begin
            nxt_direct = 1'b0;
            nxt_addr = sp_ff;
            nxt_wdata = rd_val;
            nxt_wr = 1'b1;
            nxt_done = 1'b0;
            nxt_state = lsr_pkg::ST_WRITE;
          end
          lsr_pkg::CL_RET, lsr_pkg::CL_INTERRUPT_EXIT_OP: begin
            nxt_pch = rd_val;
            nxt_sp = sp_ff - 8'h01;
            nxt_addr = sp_ff - 8'h01;
            nxt_rd = 1'b1;
            nxt_done = 1'b0;
            nxt_state = lsr_pkg::ST_STK2;
          end
          lsr_pkg::CL_POP, lsr_pkg::CL_OR_DIR_A,
          lsr_pkg::CL_OR_DIR_IMM, lsr_pkg::CL_SET_BIT_OP_BIT: begin
            if (cls_ff == lsr_pkg::CL_POP) begin
              nxt_sp = sp_ff - 8'h01;
              nxt_wdata = rd_val;
            end else begin
              nxt_wdata = alu_res;
            end
            // Writes to locally held registers land here; a pop into the
            // stack pointer overrides the decrement above.
            if (w_addr == lsr_pkg::SP_ADDR) begin
              nxt_sp = nxt_wdata;
            end else if (w_addr == lsr_pkg::ACC_ADDR) begin
              nxt_acc = nxt_wdata;
            end else begin
              nxt_direct = 1'b1;
              nxt_addr = w_addr;
              nxt_wr = 1'b1;
              nxt_done = 1'b0;
              nxt_state = lsr_pkg::ST_WRITE;
            end
          end
          default: nxt_acc = alu_res;
        endcase
      end
      lsr_pkg::ST_STK2: begin
        // Only counter, stack pointer, priority release and the defer flag change here.
        nxt_pc = {pch_ff, rd_val};
        nxt_sp = sp_ff - 8'h01;
        nxt_done = 1'b1;
        nxt_prel = (cls_ff == lsr_pkg::CL_INTERRUPT_EXIT_OP);
        nxt_state = lsr_pkg::ST_IDLE;
      end
      lsr_pkg::ST_WRITE: begin
        nxt_done = 1'b1;
        nxt_state = lsr_pkg::ST_IDLE;
      end
      default: nxt_state = lsr_pkg::ST_IDLE;
    endcase
    // The defer window opens when an interrupt return completes and closes
    // when the following instruction completes.
    if (nxt_done && state_ff != lsr_pkg::ST_IDLE) begin
      nxt_busy = 1'b0;
      nxt_defer = (state_ff == lsr_pkg::ST_STK2)
                  && (cls_ff == lsr_pkg::CL_INTERRUPT_EXIT_OP);
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= lsr_pkg::ST_IDLE;
      cls_ff <= lsr_pkg::CL_BAD;
      op1_ff <= 8'h00;
      op2_ff <= 8'h00;
      acc_ff <= lsr_pkg::ACC_RESET;
      cy_ff <= 1'b0;
      sp_ff <= lsr_pkg::SP_RESET;
      pch_ff <= 8'h00;
      pc_ff <= lsr_pkg::PC_RESET;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      direct_ff <= 1'b0;
      rd_ff <= 1'b0;
      rmw_ff <= 1'b0;
      wr_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      bad_ff <= 1'b0;
      prel_ff <= 1'b0;
      defer_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cls_ff <= nxt_cls;
      op1_ff <= nxt_op1;
      op2_ff <= nxt_op2;
      acc_ff <= nxt_acc;
      cy_ff <= nxt_cy;
      sp_ff <= nxt_sp;
      pch_ff <= nxt_pch;
      pc_ff <= nxt_pc;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      direct_ff <= nxt_direct;
      rd_ff <= nxt_rd;
      rmw_ff <= nxt_rmw;
      wr_ff <= nxt_wr;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      bad_ff <= nxt_bad;
      prel_ff <= nxt_prel;
      defer_ff <= nxt_defer;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flip-flops.
  // --------------------------------------------------------------------------
  assign MEM_ADDR = addr_ff;
  assign MEM_DIRECT = direct_ff;
  assign MEM_RD = rd_ff;
  assign MEM_RMW = rmw_ff;
  assign MEM_WR = wr_ff;
  assign MEM_WDATA = wdata_ff;
  assign EXEC_BUSY = busy_ff;
  assign EXEC_DONE = done_ff;
  assign EXEC_ILLEGAL = bad_ff;
  assign ACC_Q = acc_ff;
  assign CY_Q = cy_ff;
  assign SP_Q = sp_ff;
  assign PC_Q = pc_ff;
  assign PRIO_RELEASE = prel_ff;
  assign IRQ_DEFER = defer_ff;

endmodule : lsr_exec

// ### hdl/lsr_pkg.sv
// Shared constants and types of the logic, stack and rotate execution block.
package lsr_pkg;

  // --------------------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------------------
  localparam logic [7:0] OPC_OR_RN_BASE = 8'h48;
  localparam logic [7:0] OPC_OR_DIR = 8'h45;
  localparam logic [7:0] OPC_OR_IND_BASE = 8'h46;
  localparam logic [7:0] OPC_OR_IMM = 8'h44;
  localparam logic [7:0] OPC_OR_DIR_A = 8'h42;
  localparam logic [7:0] OPC_OR_DIR_IMM = 8'h43;
  localparam logic [7:0] OPC_OR_C_BIT = 8'h72;
  localparam logic [7:0] OPC_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OPC_POP = 8'hD0;
  localparam logic [7:0] OPC_PUSH = 8'hC0;
  localparam logic [7:0] OPC_RET = 8'h22;
  localparam logic [7:0] OPC_INTERRUPT_EXIT_OP = 8'h32;
  localparam logic [7:0] OPC_RL = 8'h23;
  localparam logic [7:0] OPC_RLC = 8'h33;
  localparam logic [7:0] OPC_RR = 8'h03;
  localparam logic [7:0] OPC_RRC = 8'h13;
  localparam logic [7:0] OPC_SET_BIT_OP_C = 8'hD3;
  localparam logic [7:0] OPC_SET_BIT_OP_BIT = 8'hD2;

  // --------------------------------------------------------------------------
  // Field layout and addresses
  // --------------------------------------------------------------------------
  localparam int REG_SEL_W = 3;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] ACC_ADDR = 8'hE0;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // --------------------------------------------------------------------------
  // Instruction lengths in bytes
  // --------------------------------------------------------------------------
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;

  // --------------------------------------------------------------------------
  // Instruction classes and sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    CL_OR_RN = 5'h00, CL_OR_DIR = 5'h01, CL_OR_IND = 5'h02,
    CL_OR_IMM = 5'h03, CL_OR_DIR_A = 5'h04, CL_OR_DIR_IMM = 5'h05,
    CL_OR_C_BIT = 5'h06, CL_OR_C_NBIT = 5'h07, CL_POP = 5'h08,
    CL_PUSH = 5'h09, CL_RET = 5'h0A, CL_INTERRUPT_EXIT_OP = 5'h0B, CL_RL = 5'h0C,
    CL_RLC = 5'h0D, CL_RR = 5'h0E, CL_RRC = 5'h0F, CL_SET_BIT_OP_C = 5'h10,
    CL_SET_BIT_OP_BIT = 5'h11, CL_BAD = 5'h12
  } lsr_cls_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_PTR = 3'h1, ST_OPND = 3'h2, ST_STK2 = 3'h3,
    ST_WRITE = 3'h4
  } lsr_state_t;

endpackage : lsr_pkg

// ### hdl/lsr_addr.sv
// Address forming for working registers and addressable bits.
`timescale 1ns/1ps
module lsr_addr (
  input wire logic [1:0] bank,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] bit_addr,
  output logic [7:0] reg_addr,
  output logic [7:0] bit_byte,
  output logic [2:0] bit_idx
);

  // --------------------------------------------------------------------------
  // Working register and bit byte addresses
  // --------------------------------------------------------------------------
  // Registers sit in eight-byte banks at the bottom of internal RAM.
  assign reg_addr = {3'h0, bank, reg_sel};
  // Low bit addresses live in the bit area, high ones in registers whose
  // address is a multiple of eight.
  assign bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'h0}
                                : {lsr_pkg::BIT_AREA_HI, bit_addr[6:3]};
  assign bit_idx = bit_addr[2:0];

endmodule : lsr_addr

// ### hdl/lsr_alu.sv
// Byte and carry operations: OR forms, rotates and bit set.
`timescale 1ns/1ps
module lsr_alu (
  input wire lsr_pkg::lsr_cls_t cls,
  input wire logic [7:0] acc,
  input wire logic cy,
  input wire logic [7:0] opnd,
  input wire logic [7:0] op1,
  input wire logic [7:0] op2,
  input wire logic [2:0] bit_idx,
  output logic [7:0] res,
  output logic res_cy
);

  logic [7:0] mask;
  logic sel_bit;

  // --------------------------------------------------------------------------
  // Bit selection
  // --------------------------------------------------------------------------
  // One decoder term per bit position of the addressed byte.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_mask
      assign mask[g] = (bit_idx == 3'(g));
    end
  endgenerate
  assign sel_bit = |(opnd & mask);

  // --------------------------------------------------------------------------
  // Result; carry is held unless the operation names it.
  // --------------------------------------------------------------------------
  always_comb begin
    res = acc;
    res_cy = cy;
    case (cls)
      lsr_pkg::CL_OR_RN,
      lsr_pkg::CL_OR_DIR,
      lsr_pkg::CL_OR_IND: res = acc | opnd;
      lsr_pkg::CL_OR_IMM: res = acc | op1;
      lsr_pkg::CL_OR_DIR_A: res = opnd | acc;
      lsr_pkg::CL_OR_DIR_IMM: res = opnd | op2;
      lsr_pkg::CL_OR_C_BIT: res_cy = cy | sel_bit;
      lsr_pkg::CL_OR_C_NBIT: res_cy = cy | ~sel_bit;
      lsr_pkg::CL_RL: res = {acc[6:0], acc[7]};
      lsr_pkg::CL_RLC: begin
        res = {acc[6:0], cy};
        res_cy = acc[7];
      end
      lsr_pkg::CL_RR: res = {acc[0], acc[7:1]};
      lsr_pkg::CL_RRC: begin
        res = {cy, acc[7:1]};
        res_cy = acc[0];
      end
      lsr_pkg::CL_SET_BIT_OP_C: res_cy = 1'b1;
      lsr_pkg::CL_SET_BIT_OP_BIT: res = opnd | mask;
      default: begin
        res = acc;
        res_cy = cy;
      end
    endcase
  end

endmodule : lsr_alu

// ### verif/lsr_exec_props.sv
// Port assertions for the execution sequencer.
`timescale 1ns/1ps
module lsr_exec_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic EXEC_START,
  input wire logic [7:0] EXEC_OPCODE,
  input wire logic EXEC_BUSY,
  input wire logic EXEC_DONE,
  input wire logic MEM_RD,
  input wire logic MEM_RMW,
  input wire logic MEM_DIRECT,
  input wire logic [7:0] ACC_Q,
  input wire logic CY_Q,
  input wire logic [7:0] SP_Q,
  input wire logic PRIO_RELEASE,
  input wire logic IRQ_DEFER
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Sequences
  // ----
  // An instruction is taken only while the sequencer is idle.
  sequence s_go(logic [7:0] op);
    EXEC_START && !EXEC_BUSY && EXEC_OPCODE == op;
  endsequence
  // Returns fetch both counter bytes from internal RAM, not direct space.
  sequence s_pop2;
    MEM_RD && !MEM_DIRECT ##1 MEM_RD && !MEM_DIRECT;
  endsequence
  // ----
  // Properties
  // ----
  // Rotates are checked by undoing them, so one $past of the old value does.
  AST_RMW: assert property (MEM_RMW |-> MEM_RD)
    else $error("latch read without read strobe");
  AST_RL: assert property (s_go(8'h23) |=>
    {ACC_Q[0], ACC_Q[7:1]} == $past(ACC_Q) && CY_Q == $past(CY_Q))
    else $error("rotate left wrong");
  AST_RLC: assert property (s_go(8'h33) |=>
    {CY_Q, ACC_Q} == {$past(ACC_Q), $past(CY_Q)})
    else $error("rotate left through carry wrong");
  AST_RR: assert property (s_go(8'h03) |=>
    {ACC_Q[6:0], ACC_Q[7]} == $past(ACC_Q) && CY_Q == $past(CY_Q))
    else $error("rotate right wrong");
  AST_RRC: assert property (s_go(8'h13) |=>
    {ACC_Q, CY_Q} == {$past(CY_Q), $past(ACC_Q)})
    else $error("rotate right through carry wrong");
  AST_SET_BIT_OP: assert property (s_go(8'hD3) |=> CY_Q && EXEC_DONE)
    else $error("carry set wrong");
  AST_PUSH: assert property (s_go(8'hC0) |=>
    SP_Q == $past(SP_Q) + 8'h01)
    else $error("push pointer step wrong");
  AST_RET: assert property (s_go(8'h22) |=> s_pop2 ##1
    EXEC_DONE && SP_Q == $past(SP_Q, 3) - 8'h02)
    else $error("return sequence wrong");
  AST_INTERRUPT_EXIT_OP: assert property (s_go(8'h32) |->
    ##3 PRIO_RELEASE && IRQ_DEFER)
    else $error("interrupt return release wrong");
endmodule : lsr_exec_chk

// ### verif/lsr_exec_tb.sv
// Self-checking bench for the execution sequencer.
`timescale 1ns/1ps
module lsr_exec_tb;
  localparam logic [7:0] PINS = 8'h5A;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic EXEC_START = 1'b0;
  logic [7:0] EXEC_OPCODE = 8'h00, EXEC_OPND1 = 8'h00, EXEC_OPND2 = 8'h00;
  logic [1:0] REG_BANK = 2'h0;
  logic [7:0] MEM_RDATA, MEM_ADDR, MEM_WDATA, ACC_Q, SP_Q, rd_val, op, r;
  logic MEM_DIRECT, MEM_RD, MEM_RMW, MEM_WR, EXEC_BUSY, EXEC_DONE;
  logic EXEC_ILLEGAL, CY_Q, PRIO_RELEASE, IRQ_DEFER, x_ill;
  logic [15:0] PC_Q, x_pc = 16'h0000;
  logic [7:0] ram [256];
  logic [7:0] x_ram [256];
  logic [7:0] port_ff = 8'h04, x_port = 8'h04, x_acc = 8'h00, x_sp = 8'h07;
  logic x_cy = 1'b0;
  logic [7:0] ops [19] = '{8'h48, 8'h45, 8'h46, 8'h44, 8'h42, 8'h43, 8'h72,
    8'hA0, 8'hD0, 8'hC0, 8'h22, 8'h32, 8'h23, 8'h33, 8'h03, 8'h13, 8'hD3,
    8'hD2, 8'hA5};
  logic [23:0] hand [7] = '{24'hD08100, 24'hC03000, 24'hD03100, 24'h439032,
    24'h459000, 24'h429000, 24'hA50000};
  int errors = 0, checks_done = 0, cycles = 0, seed = 32'h07EA;
  initial forever #5 SYS_CLK = ~SYS_CLK;
  lsr_exec u_dut (.*);
  // Memory: a port returns its latch only on read-modify-write, else pins.
  // A strobe-less bus shows the inverse so stale data never looks right.
  always_comb begin
    rd_val = ram[MEM_ADDR];
    if (MEM_DIRECT && MEM_ADDR[7]) rd_val = MEM_RMW ? port_ff : PINS;
    MEM_RDATA = MEM_RD ? rd_val : ~rd_val;
  end
  // Writes land at the strobe edge; the cycle counter cuts a hang short.
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (MEM_WR && MEM_DIRECT && MEM_ADDR[7]) port_ff <= MEM_WDATA;
    else if (MEM_WR) ram[MEM_ADDR] <= MEM_WDATA;
    if (cycles == 10000) begin
      errors++;
      conclude();
    end
  end
  // ----
  // Reference model
  // ----
  function automatic logic [7:0] rdd(input logic [7:0] a, input logic rmw);
    return a == 8'h90 ? (rmw ? x_port : PINS) : x_ram[a];
  endfunction : rdd
  task automatic wrd(input logic [7:0] a, v);
    if (a == 8'h90) x_port = v;
    else x_ram[a] = v;
  endtask : wrd
  task automatic predict(input logic [7:0] op, a, d, input logic [1:0] bk);
    logic [7:0] b;
    logic [7:0] v;
    b = a[7] ? {a[7:3], 3'h0} : 8'h20 + {4'h0, a[6:3]};
    x_ill = 1'b0;
    x_pc += (op inside {8'h42, 8'h44, 8'h45, 8'h72, 8'hA0, 8'hC0, 8'hD0,
      8'hD2}) ? 16'h0002 : (op == 8'h43) ? 16'h0003 : 16'h0001;
    case (op) inside
      [8'h48:8'h4F]: x_acc |= x_ram[{3'h0, bk, op[2:0]}];
      8'h45: x_acc |= rdd(a, 1'b0);
      8'h46, 8'h47: x_acc |= x_ram[x_ram[{3'h0, bk, 2'h0, op[0]}]];
      8'h44: x_acc |= a;
      8'h42: wrd(a, rdd(a, 1'b1) | x_acc);
      8'h43: wrd(a, rdd(a, 1'b1) | d);
      8'h72: x_cy |= x_ram[b][a[2:0]];
      8'hA0: x_cy |= ~x_ram[b][a[2:0]];
      8'hD0: begin
        v = x_ram[x_sp];
        x_sp -= 8'h01;
        if (a == 8'h81) x_sp = v;
        else wrd(a, v);
      end
      8'hC0: begin
        x_sp += 8'h01;
        x_ram[x_sp] = rdd(a, 1'b0);
      end
      8'h22, 8'h32: begin
        x_pc = {x_ram[x_sp], x_ram[x_sp - 8'h01]};
        x_sp -= 8'h02;
      end
      8'h23: x_acc = {x_acc[6:0], x_acc[7]};
      8'h33: {x_cy, x_acc} = {x_acc, x_cy};
      8'h03: x_acc = {x_acc[0], x_acc[7:1]};
      8'h13: {x_acc, x_cy} = {x_cy, x_acc};
      8'hD3: x_cy = 1'b1;
      8'hD2: x_ram[b][a[2:0]] = 1'b1;
      default: x_ill = 1'b1;
    endcase
  endtask : predict
  // ----
  // Driving and checking
  // ----
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic run(input logic [7:0] op, a, d);
    logic [1:0] bk;
    int n;
    bk = 2'($random(seed));
    @(posedge SYS_CLK);
    EXEC_START <= 1'b1;
    EXEC_OPCODE <= op;
    EXEC_OPND1 <= a;
    EXEC_OPND2 <= d;
    REG_BANK <= bk;
    @(posedge SYS_CLK);
    EXEC_START <= 1'b0;
    predict(op, a, d, bk);
    n = 0;
    do begin
      @(negedge SYS_CLK);
      n++;
    end while (EXEC_DONE !== 1'b1 && n < 8);
    check("done", 16'(EXEC_DONE), 16'h0001);
    check("illegal", 16'(EXEC_ILLEGAL), 16'(x_ill));
    check("acc", 16'(ACC_Q), 16'(x_acc));
    check("carry", 16'(CY_Q), 16'(x_cy));
    check("sp", 16'(SP_Q), 16'(x_sp));
    check("pc", PC_Q, x_pc);
    check("port", 16'(port_ff), 16'(x_port));
    n = 0;
    foreach (ram[i]) n += int'(ram[i] !== x_ram[i]);
    check("ram", 16'(n), 16'h0000);
  endtask : run
  task automatic conclude;
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // Corner cases first: pointer popped into itself, wrap both ways, port.
  initial begin
    foreach (ram[i]) ram[i] = 8'($random(seed));
    ram[7] = 8'hFF;
    x_ram = ram;
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    foreach (hand[i]) run(hand[i][23:16], hand[i][15:8], hand[i][7:0]);
    repeat (400) begin
      op = ops[$unsigned($random(seed)) % 19];
      r = 8'($random(seed));
      if (op == 8'h48) op[2:0] = r[2:0];
      if (op == 8'h46) op[0] = r[0];
      run(op, {1'b0, r[6:0]}, 8'($random(seed)));
    end
    conclude();
  end
endmodule : lsr_exec_tb
bind lsr_exec lsr_exec_chk u_chk (.*);
